// >>> rbm_pkg.sv
package rbm_pkg;

  // Ring geometry
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned MEM_BYTES = 16384;
  localparam int unsigned MEM_AW = 14;
  localparam logic [7:0] HDR_OFFSET = 8'h04;
  localparam logic [7:0] LAST_OFFSET = 8'hFF;
  localparam int unsigned LEN_W = 11;

  // Register byte offsets
  localparam logic [7:0] REG_RING_FIRST = 8'h00;
  localparam logic [7:0] REG_RING_END = 8'h04;
  localparam logic [7:0] REG_WRITE_PAGE = 8'h08;
  localparam logic [7:0] REG_BOUNDARY = 8'h0C;
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_MEM_ADDR = 8'h18;
  localparam logic [7:0] REG_MEM_DATA = 8'h1C;

  // Config fields
  localparam int unsigned CFG_ENABLE_BIT = 0;
  localparam int unsigned CFG_ACC_RUNT_BIT = 1;
  localparam int unsigned CFG_ACC_ERR_BIT = 2;
  localparam int unsigned CFG_W = 3;

  // Reset values
  localparam logic [7:0] RING_FIRST_RST = 8'h00;
  localparam logic [7:0] RING_END_RST = 8'h40;
  localparam logic [7:0] WRITE_PAGE_RST = 8'h01;
  localparam logic [7:0] BOUNDARY_RST = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;

  // One byte from the MAC; flags are valid on the last beat
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
    logic mcast;
    logic runt;
    logic mii_err;
    logic align_err;
    logic crc_err;
  } rbm_rx_beat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_DROP, ST_HDR} rbm_state_t;

endpackage : rbm_pkg

// >>> rbm_ring_manager.sv
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module rbm_ring_manager (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire rbm_pkg::rbm_rx_beat_t rx_beat,
  output logic rx_ready,
  output logic rx_overflow,
  output logic rx_stored
);

  logic [7:0] mem [rbm_pkg::MEM_BYTES];
  rbm_pkg::rbm_state_t state_q;
  logic [7:0] ring_first_page_q;
  logic [7:0] ring_end_page_q;
  logic [7:0] write_page_pointer_q;
  logic [7:0] boundary_q;
  logic [rbm_pkg::CFG_W-1:0] cfg_q;
  logic [7:0] cur_page_q;
  logic [7:0] offset_q;
  logic [7:0] next_free_q;
  logic [rbm_pkg::LEN_W-1:0] len_q;
  logic [1:0] hdr_idx_q;
  logic [7:0] stat_q;
  logic [7:0] ovf_cnt_q;
  logic [15:0] pkt_cnt_q;
  logic [rbm_pkg::MEM_AW-1:0] mem_addr_q;
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic rx_ready_q;
  logic rx_overflow_q;
  logic rx_stored_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  logic take;
  logic start_ok;
  logic start_full;
  logic store;
  logic finish;
  logic accept;
  logic link_need;
  logic link_block;
  logic link_ok;
  logic go_hdr;
  logic hdr_done;
  logic [7:0] wr_page;
  logic [7:0] wr_off;
  logic [7:0] link_page;
  logic [rbm_pkg::LEN_W-1:0] len_next;
  logic [7:0] stat_next;
  logic mem_we;
  logic [rbm_pkg::MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic ap;
  logic [31:0] rd_val;

  // Next page in ring order, wrapping at the end page
  function automatic logic [7:0] next_page(input logic [7:0] p, input logic [7:0] first_p,
                                           input logic [7:0] end_p);
    logic [7:0] n;
    n = p + 8'h01;
    return (n == end_p) ? first_p : n;
  endfunction : next_page

  // Receive decisions
  always_comb begin
    take = rx_beat.valid && rx_ready_q;
    start_full = (write_page_pointer_q == boundary_q);
    start_ok = take && rx_beat.first && cfg_q[rbm_pkg::CFG_ENABLE_BIT] && !start_full;
    store = (state_q == rbm_pkg::ST_IDLE) ? start_ok : (take && state_q == rbm_pkg::ST_RECV);
    wr_page = (state_q == rbm_pkg::ST_IDLE) ? write_page_pointer_q : cur_page_q;
    wr_off = (state_q == rbm_pkg::ST_IDLE) ? rbm_pkg::HDR_OFFSET : offset_q;
    finish = store && rx_beat.last;
    link_page = next_page(wr_page, ring_first_page_q, ring_end_page_q);
    link_need = store && !rx_beat.last && (wr_off == rbm_pkg::LAST_OFFSET);
    link_block = link_need && (link_page == boundary_q);
    link_ok = link_need && !link_block;
    len_next = (state_q == rbm_pkg::ST_IDLE) ? 11'h001 : len_q + 11'h001;
    stat_next = {2'b00, rx_beat.mcast, rx_beat.runt, rx_beat.mii_err, rx_beat.align_err,
                 rx_beat.crc_err,
                 !(rx_beat.runt | rx_beat.mii_err | rx_beat.align_err | rx_beat.crc_err)};
    // Good frames pass; runt or bad-check frames only when configured
    accept = stat_next[0]
             || (rx_beat.runt && cfg_q[rbm_pkg::CFG_ACC_RUNT_BIT]
                 && !(rx_beat.align_err | rx_beat.crc_err | rx_beat.mii_err))
             || ((rx_beat.align_err | rx_beat.crc_err) && cfg_q[rbm_pkg::CFG_ACC_ERR_BIT]
                 && !rx_beat.mii_err
                 && (!rx_beat.runt || cfg_q[rbm_pkg::CFG_ACC_RUNT_BIT]));
    go_hdr = finish && accept;
    hdr_done = (state_q == rbm_pkg::ST_HDR) && (hdr_idx_q == 2'd3);
  end

  // Packet memory write port: data bytes or header bytes
  always_comb begin
    mem_we = store || (state_q == rbm_pkg::ST_HDR);
    if (state_q == rbm_pkg::ST_HDR) begin
      mem_wa = {write_page_pointer_q[5:0], 6'h00, hdr_idx_q};
      case (hdr_idx_q)
        2'd0: mem_wd = stat_q;
        2'd1: mem_wd = next_free_q;
        2'd2: mem_wd = len_q[7:0];
        default: mem_wd = {5'b00000, len_q[10:8]};
      endcase
    end else begin
      mem_wa = {wr_page[5:0], wr_off};
      mem_wd = rx_beat.data;
    end
  end

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Receive state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= rbm_pkg::ST_IDLE;
    end else begin
      case (state_q)
        rbm_pkg::ST_IDLE: begin
          if (take && rx_beat.first && cfg_q[rbm_pkg::CFG_ENABLE_BIT]) begin
            if (start_full) begin
              state_q <= rx_beat.last ? rbm_pkg::ST_IDLE : rbm_pkg::ST_DROP;
            end else if (go_hdr) begin
              state_q <= rbm_pkg::ST_HDR;
            end else if (!finish) begin
              state_q <= rbm_pkg::ST_RECV;
            end
          end
        end
        rbm_pkg::ST_RECV: begin
          if (link_block) begin
            state_q <= rbm_pkg::ST_DROP;
          end else if (go_hdr) begin
            state_q <= rbm_pkg::ST_HDR;
          end else if (finish) begin
            state_q <= rbm_pkg::ST_IDLE;
          end
        end
        rbm_pkg::ST_DROP: begin
          if (take && rx_beat.last) begin
            state_q <= rbm_pkg::ST_IDLE;
          end
        end
        rbm_pkg::ST_HDR: begin
          if (hdr_done) begin
            state_q <= rbm_pkg::ST_IDLE;
          end
        end
        default: state_q <= rbm_pkg::ST_IDLE;
      endcase
    end
  end

  // Write address, length and the precomputed next free page
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_page_q <= 8'h00;
      offset_q <= 8'h00;
      len_q <= 11'h000;
      next_free_q <= 8'h00;
      stat_q <= 8'h00;
    end else if (store) begin
      offset_q <= wr_off + 8'h01;
      len_q <= len_next;
      if (state_q == rbm_pkg::ST_IDLE) begin
        cur_page_q <= write_page_pointer_q;
        next_free_q <= link_page;
      end else if (link_ok) begin
        cur_page_q <= link_page;
        next_free_q <= next_page(link_page, ring_first_page_q, ring_end_page_q);
      end
      if (finish) begin
        stat_q <= stat_next;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hdr_idx_q <= 2'd0;
    end else if (state_q == rbm_pkg::ST_HDR) begin
      hdr_idx_q <= hdr_idx_q + 2'd1;
    end else begin
      hdr_idx_q <= 2'd0;
    end
  end

  // Ready drops while the header is written so no byte is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ready_q <= 1'b0;
      rx_overflow_q <= 1'b0;
      rx_stored_q <= 1'b0;
    end else begin
      rx_ready_q <= !(go_hdr || ((state_q == rbm_pkg::ST_HDR) && !hdr_done));
      rx_overflow_q <= link_block || (state_q == rbm_pkg::ST_IDLE && take && rx_beat.first
                       && cfg_q[rbm_pkg::CFG_ENABLE_BIT] && start_full);
      rx_stored_q <= hdr_done;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_cnt_q <= 8'h00;
      pkt_cnt_q <= 16'h0000;
    end else begin
      if (rx_overflow_q) begin
        ovf_cnt_q <= ovf_cnt_q + 8'h01;
      end
      if (rx_stored_q) begin
        pkt_cnt_q <= pkt_cnt_q + 16'h0001;
      end
    end
  end

  // Bus slave: zero wait states, read data prepared at the address phase
  assign ap = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_pend_q <= ap && hwrite;
      waddr_q <= haddr[7:0];
    end
  end

  always_comb begin
    case (haddr[7:0])
      rbm_pkg::REG_RING_FIRST: rd_val = {24'h000000, ring_first_page_q};
      rbm_pkg::REG_RING_END: rd_val = {24'h000000, ring_end_page_q};
      rbm_pkg::REG_WRITE_PAGE: rd_val = {24'h000000, write_page_pointer_q};
      rbm_pkg::REG_BOUNDARY: rd_val = {24'h000000, boundary_q};
      rbm_pkg::REG_CONFIG: rd_val = {29'h00000000, cfg_q};
      rbm_pkg::REG_STATUS: rd_val = {pkt_cnt_q, ovf_cnt_q, 6'h00, state_q};
      rbm_pkg::REG_MEM_ADDR: rd_val = {18'h00000, mem_addr_q};
      rbm_pkg::REG_MEM_DATA: rd_val = {16'h0000, mem[{mem_addr_q[13:1], 1'b1}],
                                       mem[{mem_addr_q[13:1], 1'b0}]};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else begin
      hrdata_q <= (ap && !hwrite) ? rd_val : 32'h00000000;
    end
  end

  // Ring bounds, boundary and settings; host keeps them consistent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_first_page_q <= rbm_pkg::RING_FIRST_RST;
      ring_end_page_q <= rbm_pkg::RING_END_RST;
      boundary_q <= rbm_pkg::BOUNDARY_RST;
      cfg_q <= rbm_pkg::CFG_RST;
      mem_addr_q <= 14'h0000;
    end else if (wr_pend_q) begin
      case (waddr_q)
        rbm_pkg::REG_RING_FIRST: ring_first_page_q <= hwdata[7:0];
        rbm_pkg::REG_RING_END: ring_end_page_q <= hwdata[7:0];
        rbm_pkg::REG_BOUNDARY: boundary_q <= hwdata[7:0];
        rbm_pkg::REG_CONFIG: cfg_q <= hwdata[rbm_pkg::CFG_W-1:0];
        rbm_pkg::REG_MEM_ADDR: mem_addr_q <= hwdata[rbm_pkg::MEM_AW-1:0];
        default: mem_addr_q <= mem_addr_q;
      endcase
    end
  end

  // Hardware update of the write pointer wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_page_pointer_q <= rbm_pkg::WRITE_PAGE_RST;
    end else if (hdr_done) begin
      write_page_pointer_q <= next_free_q;
    end else if (wr_pend_q && waddr_q == rbm_pkg::REG_WRITE_PAGE) begin
      write_page_pointer_q <= hwdata[7:0];
    end
  end

  // Never stalls, never errors; still registered so every output leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign rx_ready = rx_ready_q;
  assign rx_overflow = rx_overflow_q;
  assign rx_stored = rx_stored_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_NO_BOUNDARY_WRITE: assert property (
    (store && state_q == rbm_pkg::ST_RECV) |-> (cur_page_q != boundary_q))
    else $error("data written into boundary page");
  AST_LINK_PAGE: assert property (
    link_ok |=> (cur_page_q == $past(link_page)) && (offset_q == 8'h00))
    else $error("link went to wrong page");
  AST_START_OFFSET: assert property (
    (store && state_q == rbm_pkg::ST_IDLE)
    |-> (mem_wa == {write_page_pointer_q[5:0], rbm_pkg::HDR_OFFSET}))
    else $error("packet did not start at offset four");
  AST_REJECT_RECLAIM: assert property (
    (finish && !accept) |=> (state_q == rbm_pkg::ST_IDLE)
    && (write_page_pointer_q == $past(write_page_pointer_q)))
    else $error("rejected packet moved the write pointer");
  AST_HDR_SEQ: assert property (
    go_hdr |=> (state_q == rbm_pkg::ST_HDR)[*4] ##1 (state_q == rbm_pkg::ST_IDLE && rx_stored))
    else $error("header sequence not four bytes");
  AST_POINTER_ADVANCE: assert property (
    hdr_done |=> (write_page_pointer_q == $past(next_free_q)) && rx_ready)
    else $error("write pointer not loaded with next free page");
  AST_STATUS_WORD: assert property (
    (state_q == rbm_pkg::ST_HDR && hdr_idx_q == 2'd0)
    |-> (mem_wd[7:6] == 2'b00) && (mem_wa[7:0] == 8'h00))
    else $error("status byte malformed");
  AST_LEN_HIGH: assert property (
    (state_q == rbm_pkg::ST_HDR && hdr_idx_q == 2'd3) |-> (mem_wd[7:3] == 5'b00000))
    else $error("length high bits not zero");
  AST_OVERFLOW_DROP: assert property (
    link_block |=> (state_q == rbm_pkg::ST_DROP) && rx_overflow
    && (write_page_pointer_q == $past(write_page_pointer_q)))
    else $error("overflow did not drop only current packet");
  AST_START_FULL_DROP: assert property (
    (state_q == rbm_pkg::ST_IDLE && start_full && take && rx_beat.first && !rx_beat.last
     && cfg_q[rbm_pkg::CFG_ENABLE_BIT])
    |=> (state_q == rbm_pkg::ST_DROP) && rx_overflow
    && (write_page_pointer_q == $past(write_page_pointer_q)))
    else $error("full ring did not drop arriving packet");

endmodule : rbm_ring_manager

// >>> rbm_mac_model.sv
`timescale 1ns/10ps
module rbm_mac_model (
  input wire logic hclk,
  input wire logic rx_ready,
  output rbm_pkg::rbm_rx_beat_t rx_beat
);
  initial rx_beat = '0;

  // Bytes carry key plus index; the last four stand for the frame check sequence
  // Error flags ride the last beat only, and each beat is held until rx_ready is seen
  task automatic send(input int len, input logic [7:0] key, input logic [4:0] flg);
    rbm_pkg::rbm_rx_beat_t b;
    @(posedge hclk);
    for (int k = 0; k < len; k++) begin
      b = '0;
      b.valid = 1'b1;
      b.first = (k == 0);
      b.last = (k == len - 1);
      b.data = key + k[7:0];
      if (b.last) begin
        {b.mcast, b.runt, b.mii_err, b.align_err, b.crc_err} = flg;
      end
      rx_beat <= b;
      do @(posedge hclk); while (rx_ready !== 1'b1);
    end
    // Released data must not keep showing the last byte
    b = '0;
    b.data = ~rx_beat.data;
    rx_beat <= b;
  endtask : send
endmodule : rbm_mac_model

// >>> rbm_ring_manager_tb.sv
`timescale 1ns/10ps
module rbm_ring_manager_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic rx_ready;
  logic rx_overflow;
  logic rx_stored;
  rbm_pkg::rbm_rx_beat_t rx_beat;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic hresp;
  logic rsp;
  int stored_seen = 0;
  int ovf_seen = 0;

  always #2.5 hclk = ~hclk;

  rbm_ring_manager i_rbm_ring_manager (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_beat(rx_beat),
    .rx_ready(rx_ready), .rx_overflow(rx_overflow), .rx_stored(rx_stored)
  );

  rbm_mac_model i_rbm_mac_model (.hclk(hclk), .rx_ready(rx_ready), .rx_beat(rx_beat));

  // Pulses last one cycle, so each edge that sees one counts it once
  always @(posedge hclk) begin
    if (rx_stored === 1'b1) begin
      stored_seen++;
    end
    if (rx_overflow === 1'b1) begin
      ovf_seen++;
    end
  end

  task automatic close_out;
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One single-word transfer; the bus ends a wait only on hready high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rsp = hresp;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(name, exp, rd);
    chk("hresp", 32'h0, {31'h0, rsp});
  endtask : rchk

  // Reads one packet-memory halfword through the address/data window
  task automatic peek(input logic [5:0] pg, input logic [7:0] off, input logic [15:0] exp);
    wr(8'h18, {18'h0, pg, off});
    rchk("mem_data", 8'h1C, {16'h0, exp});
  endtask : peek

  // Header and pulses take a fixed 5 cycles after the last beat
  task automatic pkt(input int len, input logic [7:0] key, input logic [4:0] flg);
    i_rbm_mac_model.send(len, key, flg);
    repeat (8) @(posedge hclk);
  endtask : pkt

  initial begin
    #100000;
    mismatches++;
    $display("mismatch watchdog expected done seen hang");
    close_out();
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("ring_first_page", 8'h00, 32'h0);
    rchk("ring_end_page", 8'h04, 32'h40);
    rchk("write_page_pointer", 8'h08, 32'h1);
    rchk("boundary", 8'h0C, 32'h0);
    rchk("config", 8'h10, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    // Ring is pages 1 to 5; boundary at 4 keeps the far pages unread
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h6);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h4);
    wr(8'h10, 32'h1);
    rchk("ring_end_page", 8'h04, 32'h6);
    $display("test registers done");
    pkt(300, 8'h10, 5'b10000);
    rchk("write_page_pointer", 8'h08, 32'h3);
    peek(6'h01, 8'h00, 16'h0321);
    peek(6'h01, 8'h02, 16'h012C);
    peek(6'h01, 8'h04, 16'h1110);
    peek(6'h02, 8'h00, 16'h0D0C);
    peek(6'h02, 8'h2E, 16'h3B3A);
    $display("test two-page packet done");
    pkt(300, 8'h40, 5'b00000);
    rchk("write_page_pointer", 8'h08, 32'h3);
    rchk("status", 8'h14, 32'h0001_0100);
    peek(6'h01, 8'h00, 16'h0321);
    peek(6'h02, 8'h2E, 16'h3B3A);
    chk("rx_overflow_count", 32'h1, ovf_seen);
    $display("test overflow done");
    // Host has read nothing yet, so the boundary moves to the oldest packet
    wr(8'h0C, 32'h1);
    pkt(20, 8'h70, 5'b00001);
    rchk("write_page_pointer", 8'h08, 32'h3);
    rchk("status", 8'h14, 32'h0001_0100);
    $display("test rejected packet done");
    wr(8'h10, 32'h5);
    pkt(10, 8'hA0, 5'b00001);
    rchk("write_page_pointer", 8'h08, 32'h4);
    peek(6'h03, 8'h00, 16'h0402);
    peek(6'h03, 8'h02, 16'h000A);
    $display("test accepted error packet done");
    pkt(300, 8'hC0, 5'b00000);
    rchk("write_page_pointer", 8'h08, 32'h1);
    peek(6'h04, 8'h00, 16'h0101);
    peek(6'h04, 8'h02, 16'h012C);
    peek(6'h05, 8'h00, 16'hBDBC);
    rchk("status", 8'h14, 32'h0003_0100);
    chk("rx_stored_count", 32'h3, stored_seen);
    $display("test wrap done");
    // Write pointer now equals the boundary, so the next packet finds the ring full
    pkt(20, 8'hE0, 5'b00000);
    rchk("write_page_pointer", 8'h08, 32'h1);
    rchk("status", 8'h14, 32'h0003_0200);
    chk("rx_overflow_count", 32'h2, ovf_seen);
    $display("test full at start done");
    wr(8'h0C, 32'h4);
    wr(8'h10, 32'h3);
    pkt(8, 8'h20, 5'b01000);
    rchk("write_page_pointer", 8'h08, 32'h2);
    peek(6'h01, 8'h00, 16'h0210);
    peek(6'h01, 8'h02, 16'h0008);
    rchk("status", 8'h14, 32'h0004_0200);
    chk("rx_stored_count", 32'h4, stored_seen);
    $display("test accepted runt done");
    close_out();
  end
endmodule : rbm_ring_manager_tb
